/* rtl/sac_channel_control.sv */
// Sequencer and result formatter around the successive approximation core
`timescale 1ns/1ps
module sac_channel_control
    import sac_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_CYC
) (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire sac_chcfg_t            chCfg [NUM_CH],
    input  wire logic [1:0]            resolution,
    input  wire logic [2:0]            oversamplingExponent,
    input  wire logic [15:0]           bufferCapacityCount,
    input  wire logic                  timerMode,
    input  wire logic [11:0]           timerPeriod,
    input  wire logic                  startTask,
    input  wire logic                  sampleTask,
    input  wire logic                  eventLinkSample,
    input  wire logic                  stopTask,
    input  wire logic                  offsetCalibrationTask,
    input  wire logic [11:0]           coreResult,
    output logic [3:0]                 muxPos,
    output logic [3:0]                 muxNeg,
    output logic                       coreSample,
    output sac_result_t                resultOut,
    output logic                       sampleDoneEvent,
    output logic                       accumulatedResultEvent,
    output logic                       endEvent,
    output logic                       stoppedEvent,
    output logic                       startedEvent,
    output logic                       calibrationFinishedEvent,
    output logic                       scanActive,
    output logic [15:0]                resultAmount
);
    // Calibration count must fit the 16-bit cycle counter
    if (CAL_CYCLES < 1 || CAL_CYCLES > 65536) begin : g_bad_cal
        $error("CAL_CYCLES must lie between 1 and 65536");
    end

    //------------------------------------------------------------------
    // Channel decode
    //------------------------------------------------------------------
    function automatic logic [3:0] countEn(input logic [NUM_CH-1:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < NUM_CH; i++)
            c = c + {3'h0, v[i]};
        return c;
    endfunction

    // Next enabled slot after idx (all ones: from the first), else 8
    function automatic logic [3:0] nextEn(input logic [NUM_CH-1:0] v,
                                          input logic [3:0] idx);
        logic [3:0] n;
        n = 4'h8;
        for (int i = NUM_CH - 1; i >= 0; i--)
            if (v[i] && (idx == 4'hF || 4'(i) > idx))
                n = 4'(i);
        return n;
    endfunction

    logic [NUM_CH-1:0] chEnabled;
    for (genvar g = 0; g < NUM_CH; g++) begin : g_en
        assign chEnabled[g] = (chCfg[g].posSel != SEL_NC);
    end
    wire logic [3:0] enCount   = countEn(chEnabled);
    wire logic       anyEn     = (enCount != 4'h0);
    wire logic       scanMode  = (enCount > 4'h1);
    wire logic [3:0] firstCh   = nextEn(chEnabled, 4'hF);

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    sac_state_t  state_reg, state_next;
    logic [2:0]  ch_reg;
    logic [15:0] cnt_reg;
    logic [7:0]  burst_reg;           // Conversions left in oversampling_exponent set
    logic [19:0] acc_reg;
    logic        running_reg;
    logic [15:0] amount_reg;
    logic [11:0] timer_reg;
    logic        timerOn_reg;

    wire sac_chcfg_t curCfg  = chCfg[ch_reg];
    wire logic [7:0] osTotal = 8'h01 << oversamplingExponent;
    wire logic [15:0] acqCyc = 16'(({13'h0, curCfg.acqCode} + 16'h1)
                                   * 16'(ACQ_UNIT));
    wire logic       timerTick = timerOn_reg && (timer_reg == 12'h000);
    wire logic       trig = sampleTask || eventLinkSample
                            || timerTick;
    wire logic       go   = trig && anyEn && running_reg &&
                            (state_reg == ST_IDLE);
    wire logic       convDone = (state_reg == ST_CONV) &&
                                (cnt_reg == 16'(CONV_CYC - 1));
    wire logic [3:0] nxt = nextEn(chEnabled, {1'b0, ch_reg});
    wire logic       setDone = convDone && (burst_reg == 8'h01);
    wire logic       moreScan = scanMode && (nxt != 4'h8);

    // Inputs to the core mux: negative grounded unless differential
    assign muxPos = curCfg.posSel;
    assign muxNeg = curCfg.diffMode ? curCfg.negSel
                                    : SEL_GROUND;
    assign coreSample = (state_reg == ST_ACQ);
    assign scanActive = scanMode;
    assign resultAmount = amount_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (offsetCalibrationTask)
                    state_next = ST_CAL;
                else if (go)
                    state_next = ST_ACQ;
            end
            ST_ACQ: begin
                if (cnt_reg >= acqCyc - 16'h1)
                    state_next = ST_CONV;
            end
            ST_CONV: begin
                if (convDone)
                    state_next = ST_NEXT;
            end
            ST_NEXT: begin
                // Burst repeats in place; scan steps to the next slot
                if (burst_reg != 8'h00 && curCfg.burst)
                    state_next = ST_ACQ;
                else if (burst_reg == 8'h00 && moreScan)
                    state_next = ST_ACQ;
                else
                    state_next = ST_IDLE;
            end
            ST_CAL: begin
                if (cnt_reg == 16'(CAL_CYCLES - 1))
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
        if (stopTask)
            state_next = ST_IDLE;
    end

    //------------------------------------------------------------------
    // Result formatting
    //------------------------------------------------------------------
    // Core gives 12 bits; resolution trims LSBs, differential halves
    // the positive span so the top bit becomes the sign.
    function automatic logic [15:0] fmt(input logic [11:0] raw,
                                        input logic [1:0] res,
                                        input logic diff);
        logic [11:0] v;
        logic [15:0] r;
        unique case (res)
            RES_8:   v = {4'h0, raw[11:4]};
            RES_10:  v = {2'h0, raw[11:2]};
            default: v = raw;
        endcase
        if (diff) begin
            // Signed: top bit of selected width is the sign
            unique case (res)
                RES_8:   r = {{8{v[7]}}, v[7:0]};
                RES_10:  r = {{6{v[9]}}, v[9:0]};
                default: r = {{4{v[11]}}, v[11:0]};
            endcase
        end else begin
            r = {4'h0, v};
        end
        return r;
    endfunction

    wire logic [15:0] sampleVal = fmt(coreResult, resolution,
                                      curCfg.diffMode);
    wire logic [19:0] accSum = acc_reg + {{4{sampleVal[15]}}, sampleVal};
    // 14-bit only through oversampling: accumulate then rescale
    wire logic [15:0] osVal = (resolution == RES_14)
        ? 16'(accSum >>> (oversamplingExponent - 3'h2 > 3'h5 ? 3'h0 :
                          oversamplingExponent - 3'h2))
        : 16'(accSum >>> oversamplingExponent);
    wire logic       amountFull = (amount_reg + 16'h1 >= bufferCapacityCount);

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= CNT_RST;
            ch_reg    <= 3'h0;
            burst_reg <= 8'h00;
            acc_reg   <= 20'h00000;
            running_reg <= 1'b0;
            amount_reg <= CNT_RST;
            timer_reg <= 12'h000;
            timerOn_reg <= 1'b0;
            resultOut <= '0;
            sampleDoneEvent <= 1'b0;
            accumulatedResultEvent <= 1'b0;
            endEvent <= 1'b0;
            stoppedEvent <= 1'b0;
            startedEvent <= 1'b0;
            calibrationFinishedEvent <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= (state_next != state_reg) ? CNT_RST : cnt_reg + 16'h1;
            sampleDoneEvent <= convDone && !stopTask;
            accumulatedResultEvent <= setDone && !stopTask;
            endEvent <= 1'b0;
            stoppedEvent <= stopTask;
            startedEvent <= startTask;
            calibrationFinishedEvent <= (state_reg == ST_CAL) &&
                (cnt_reg == 16'(CAL_CYCLES - 1));
            resultOut.valid <= 1'b0;
            if (startTask) begin
                running_reg <= 1'b1;
                amount_reg  <= CNT_RST;
                timerOn_reg <= timerMode && !scanMode;
                timer_reg   <= timerPeriod;
            end
            if (timerOn_reg)
                timer_reg <= (timer_reg == 12'h000) ? timerPeriod
                                                    : timer_reg - 12'h001;
            if (go) begin
                ch_reg    <= firstCh[2:0];
                burst_reg <= osTotal;
                acc_reg   <= 20'h00000;
            end
            if (convDone) begin
                burst_reg <= burst_reg - 8'h01;
                acc_reg   <= setDone ? 20'h00000 : accSum;
            end
            if (setDone && !stopTask) begin
                resultOut.valid <= 1'b1;
                resultOut.chan  <= ch_reg;
                resultOut.value <= osVal;
                amount_reg <= amount_reg + 16'h1;
                if (amountFull) begin
                    endEvent    <= 1'b1;
                    running_reg <= 1'b0;
                    timerOn_reg <= 1'b0;
                end
            end
            if (state_reg == ST_NEXT && burst_reg == 8'h00 && moreScan) begin
                ch_reg    <= nxt[2:0];
                burst_reg <= osTotal;
            end
            if (stopTask) begin
                running_reg <= 1'b0;
                timerOn_reg <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    // Last conversion of a set, and what it must show one cycle later
    sequence s_set_last;
        setDone && !stopTask;
    endsequence
    sequence s_set_out;
        resultOut.valid && accumulatedResultEvent && sampleDoneEvent;
    endsequence
    // Scan step with slots left, and the end of an acquisition
    sequence s_scan_step;
        state_reg == ST_NEXT && burst_reg == 8'h00 && moreScan && !stopTask;
    endsequence
    sequence s_acq_end;
        state_reg == ST_ACQ && state_next == ST_CONV;
    endsequence

    a_neg_ground: assert property (@(posedge mclk) disable iff (srst)
        !curCfg.diffMode |-> muxNeg == SEL_GROUND)
        else $error("negative input not grounded in single-ended");
    a_stop_event: assert property (@(posedge mclk) disable iff (srst)
        stopTask |=> stoppedEvent)
        else $error("stop task gave no stopped event");
    a_no_enable: assert property (@(posedge mclk) disable iff (srst)
        (state_reg == ST_IDLE && !anyEn && !offsetCalibrationTask)
        |=> state_reg == ST_IDLE)
        else $error("conversion started with no slot enabled");
    a_cal_done: assert property (@(posedge mclk) disable iff (srst)
        $rose(calibrationFinishedEvent) |-> $past(state_reg) == ST_CAL)
        else $error("calibration event without calibration");
    a_end_count: assert property (@(posedge mclk) disable iff (srst)
        endEvent |-> amount_reg >= bufferCapacityCount)
        else $error("end event before capacity reached");
    a_acc_event: assert property (@(posedge mclk) disable iff (srst)
        accumulatedResultEvent |-> $past(burst_reg) == 8'h01)
        else $error("accumulated event before full set");
    a_scan_mode: assert property (@(posedge mclk) disable iff (srst)
        scanActive == (countEn(chEnabled) >= 4'h2))
        else $error("scan mode does not follow enabled count");
    a_result_sext: assert property (@(posedge mclk) disable iff (srst)
        resultOut.valid && resolution == RES_8 && burst_reg == 8'h00
        && oversamplingExponent == 3'h0 |-> resultOut.value[15:8]
        == {8{resultOut.value[7]}} || resultOut.value[15:8] == 8'h00)
        else $error("8-bit result not extended to 16 bits");
    a_set_walk: assert property (@(posedge mclk) disable iff (srst)
        s_set_last |=> s_set_out)
        else $error("set end without result and events");
    a_scan_step: assert property (@(posedge mclk) disable iff (srst)
        s_scan_step |=> state_reg == ST_ACQ && ch_reg > $past(ch_reg))
        else $error("scan did not step to a later slot");
    a_stop_halts: assert property (@(posedge mclk) disable iff (srst)
        stopTask |=> state_reg == ST_IDLE && !resultOut.valid)
        else $error("stop task did not halt the sequencer");
    a_acq_time: assert property (@(posedge mclk) disable iff (srst)
        s_acq_end
        |-> cnt_reg == acqCyc - 16'h1)
        else $error("acquisition time differs from slot setting");
endmodule

/* include/sac_pkg.sv */
// Package: constants and types of the converter channel control block
//----------------------------------------------------------------------
// Contract
// - Eight channel slots, each fully configurable
// - Slot enabled when positive select connected
// - One slot one-shot, more slots scan
// - Negative select used only when differential
// - Single-ended default grounds negative input
// - Result scaled by resolution minus mode bit
// - Resolution 8/10/12; 14 via oversampling
// - Every sample is 16-bit two's complement; negative differential results lose the sign from exponent 5 (14-bit: 7)
// - Offset calibration then finished event
// - Sample task from software or link
// - Scan spaces channels acquisition plus conversion
// - Scan mixes single-ended and differential slots
// - Selects route any input pin or supply
// - Sample-done and buffer-full interrupt sources
// - Internal timer gives continuous sampling in one-slot mode only
// - End event when results reach capacity
// - Stop task always yields stopped event
// - Accumulated event after full oversampling_exponent set
// - Burst takes two-to-exponent conversions back-to-back
//----------------------------------------------------------------------
package sac_pkg;
    localparam int          NUM_CH      = 8;
    // Input select codes: 0 not connected, 1..8 pins, 9 supply
    localparam logic [3:0]  SEL_NC      = 4'h0;
    localparam logic [3:0]  SEL_SUPPLY  = 4'h9;
    localparam logic [3:0]  SEL_GROUND  = 4'hF;
    // Resolution codes
    localparam logic [1:0]  RES_8       = 2'h0;
    localparam logic [1:0]  RES_10      = 2'h1;
    localparam logic [1:0]  RES_12      = 2'h2;
    localparam logic [1:0]  RES_14      = 2'h3;
    localparam logic [2:0]  RES_RST     = 3'h0;
    // Conversion time and calibration time
    localparam int          CONV_NS     = 2000;
    localparam int          CLK_NS      = 8;
    localparam int          CONV_CYC    = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int          CAL_NS      = 40000;
    localparam int          CAL_CYC     = (CAL_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] CNT_RST     = 16'h0000;

    typedef struct packed {
        logic [3:0] posSel;
        logic [3:0] negSel;
        logic       diffMode;
        logic       burst;
        logic [2:0] acqCode;   // Acquisition time of (code + 1) ACQ_UNIT steps
    } sac_chcfg_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  chan;
        logic [15:0] value;
    } sac_result_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ACQ  = 3'b001,
        ST_CONV = 3'b010,
        ST_NEXT = 3'b011,
        ST_CAL  = 3'b100
    } sac_state_t;

    localparam int          ACQ_UNIT    = 125;   // 1 us per code step
endpackage

/* tb/sac_front_model.sv */
// Analog front end and result memory writer model
`timescale 1ns/1ps
module sac_front_model
    import sac_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [3:0]  muxPos,
    input  wire logic [3:0]  muxNeg,
    input  wire logic        coreSample,
    input  wire sac_result_t resultOut,
    output logic      [11:0] coreResult,
    output int               storedCount
);
    logic [15:0] memory [64];

    initial begin
        coreResult = 12'h000;
        storedCount = 0;
    end

    // Held code follows the routed inputs; flips once the result is taken
    always @(posedge mclk) begin
        if (coreSample === 1'b1)
            coreResult <= {muxPos, muxNeg, 4'h3};
        else if (resultOut.valid === 1'b1)
            coreResult <= ~coreResult;
        if (resultOut.valid === 1'b1) begin
            memory[storedCount % 64] <= resultOut.value;
            storedCount <= storedCount + 1;
        end
    end
endmodule

/* tb/sac_tb.sv */
// Self-checking bench for the converter channel control block
`timescale 1ns/1ps
module tb
    import sac_pkg::*;
;
    localparam int CAL_TB = 16;
    logic        mclk;
    logic        srst;
    sac_chcfg_t  chCfg [NUM_CH];
    logic [1:0]  resolution;
    logic [2:0]  oversamplingExponent;
    logic [15:0] bufferCapacityCount;
    logic        timerMode;
    logic [11:0] timerPeriod;
    logic [4:0]  taskPulse;
    logic [11:0] coreResult;
    logic [3:0]  muxPos;
    logic [3:0]  muxNeg;
    logic        coreSample;
    sac_result_t resultOut;
    logic        sampleDoneEvent;
    logic        accumulatedResultEvent;
    logic        endEvent;
    logic        stoppedEvent;
    logic        startedEvent;
    logic        calibrationFinishedEvent;
    logic        scanActive;
    logic [15:0] resultAmount;
    int          storedCount;
    int          evCnt [6] = '{default: 0};
    int          cyc = 0;
    int          doneCyc [$];
    logic [2:0]  chanQ [$];
    logic [15:0] valQ [$];
    logic [3:0]  seenPos;
    logic [3:0]  seenNeg;
    int          badCount = 0;
    int          nChecks = 0;

    sac_channel_control #(.CAL_CYCLES(CAL_TB)) i_dut (
        .mclk(mclk), .srst(srst), .chCfg(chCfg), .resolution(resolution),
        .oversamplingExponent(oversamplingExponent),
        .bufferCapacityCount(bufferCapacityCount), .timerMode(timerMode),
        .timerPeriod(timerPeriod), .startTask(taskPulse[0]),
        .sampleTask(taskPulse[1]), .eventLinkSample(taskPulse[2]),
        .stopTask(taskPulse[3]), .offsetCalibrationTask(taskPulse[4]),
        .coreResult(coreResult), .muxPos(muxPos), .muxNeg(muxNeg),
        .coreSample(coreSample), .resultOut(resultOut),
        .sampleDoneEvent(sampleDoneEvent),
        .accumulatedResultEvent(accumulatedResultEvent),
        .endEvent(endEvent), .stoppedEvent(stoppedEvent),
        .startedEvent(startedEvent),
        .calibrationFinishedEvent(calibrationFinishedEvent),
        .scanActive(scanActive), .resultAmount(resultAmount));

    sac_front_model i_front (
        .mclk(mclk), .muxPos(muxPos), .muxNeg(muxNeg),
        .coreSample(coreSample), .resultOut(resultOut),
        .coreResult(coreResult), .storedCount(storedCount));

    //------------------------------------------------------------------
    // Monitor and helpers
    //------------------------------------------------------------------
    always @(posedge mclk) begin
        cyc++;
        if (sampleDoneEvent === 1'b1) begin
            evCnt[0]++;
            doneCyc.push_back(cyc);
        end
        if (accumulatedResultEvent === 1'b1) evCnt[1]++;
        if (endEvent === 1'b1) evCnt[2]++;
        if (stoppedEvent === 1'b1) evCnt[3]++;
        if (startedEvent === 1'b1) evCnt[4]++;
        if (calibrationFinishedEvent === 1'b1) evCnt[5]++;
        if (coreSample === 1'b1) begin
            seenPos = muxPos;
            seenNeg = muxNeg;
        end
        if (resultOut.valid === 1'b1) begin
            chanQ.push_back(resultOut.chan);
            valQ.push_back(resultOut.value);
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // 0 start, 1 sample, 2 link sample, 3 stop, 4 calibration
    task automatic pulse(input int k);
        @(posedge mclk);
        taskPulse <= 5'h01 << k;
        @(posedge mclk);
        taskPulse <= 5'h00;
    endtask

    task automatic waitFor(input int k, input int target, input int bound);
        int n;
        n = 0;
        while (evCnt[k] < target && n < bound) begin
            @(negedge mclk);
            n++;
        end
        check($sformatf("event %0d count", k), evCnt[k] >= target, 1);
        if (evCnt[k] < target) endOfTest();
    endtask

    task automatic slot(input int i, input logic [3:0] p, input logic [3:0] n,
                        input logic d, input logic b, input logic [2:0] a);
        @(posedge mclk);
        chCfg[i] <= '{p, n, d, b, a};
    endtask

    //------------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------------
    task automatic sIdle();
        int d0;
        slot(6, SEL_NC, 4'h2, 1'b1, 1'b1, 3'h2);
        d0 = evCnt[0];
        pulse(0);
        waitFor(4, 1, 20);
        pulse(1);
        repeat (600) @(negedge mclk);
        check("done with no slot", evCnt[0], d0);
        check("results with no slot", chanQ.size(), 0);
    endtask

    task automatic sOneShot();
        int d0;
        int t0;
        int lat;
        // No pin used here is claimed by a comparator
        slot(3, 4'h2, 4'h5, 1'b0, 1'b0, 3'h0);
        @(negedge mclk);
        check("scan flag one slot", scanActive, 0);
        d0 = evCnt[0];
        t0 = cyc;
        pulse(1);
        waitFor(0, d0 + 1, 1000);
        check("positive select", seenPos, 4'h2);
        check("negative grounded", seenNeg, SEL_GROUND);
        check("result slot", chanQ[$], 3'h3);
        check("12-bit result", valQ[$], 16'h02F3);
        check("accumulated count", evCnt[1], 1);
        lat = doneCyc[$] - t0;
        check("one-shot latency", lat >= 375 && lat <= 385, 1);
    endtask

    task automatic sScan();
        int d0;
        int e0;
        int n0;
        int sp;
        slot(3, SEL_NC, 4'h0, 1'b0, 1'b0, 3'h0);
        slot(1, SEL_SUPPLY, 4'h3, 1'b0, 1'b0, 3'h0);
        slot(5, 4'h8, 4'h1, 1'b1, 1'b0, 3'h1);
        resolution <= RES_8;
        bufferCapacityCount <= 16'h0002;
        pulse(0);
        @(negedge mclk);
        check("scan flag two slots", scanActive, 1);
        d0 = evCnt[0];
        e0 = evCnt[2];
        n0 = chanQ.size();
        pulse(2);
        waitFor(0, d0 + 2, 2000);
        check("first scan slot", chanQ[n0], 3'h1);
        check("second scan slot", chanQ[n0 + 1], 3'h5);
        check("differential negative", seenNeg, 4'h1);
        sp = doneCyc[$] - doneCyc[$ - 1];
        check("slot spacing", sp >= 500 && sp <= 506, 1);
        check("single-ended range", valQ[$ - 1][15:8], 8'h00);
        check("sign extension", valQ[$][15:7] == 9'h000
              || valQ[$][15:7] == 9'h1FF, 1);
        repeat (20) @(negedge mclk);
        check("end event", evCnt[2], e0 + 1);
        check("result amount", resultAmount, 16'h0002);
        check("differential value", valQ[$], 16'hFF81);
        check("stored results", storedCount, n0 + 2);
    endtask

    task automatic sBurst();
        int d0;
        int a0;
        slot(1, SEL_NC, 4'h0, 1'b0, 1'b0, 3'h0);
        slot(5, SEL_NC, 4'h0, 1'b0, 1'b0, 3'h0);
        slot(0, 4'h4, 4'h0, 1'b0, 1'b1, 3'h0);
        oversamplingExponent <= 3'h2;
        resolution <= RES_14;
        bufferCapacityCount <= 16'h0010;
        pulse(0);
        d0 = evCnt[0];
        a0 = evCnt[1];
        pulse(1);
        waitFor(1, a0 + 1, 2000);
        repeat (10) @(negedge mclk);
        check("burst conversions", evCnt[0], d0 + 4);
        check("one accumulated", evCnt[1], a0 + 1);
        check("oversampled value", valQ[$], 16'h13CC);
    endtask

    task automatic sTimer();
        int d0;
        int s0;
        slot(0, 4'h4, 4'h0, 1'b0, 1'b0, 3'h0);
        oversamplingExponent <= 3'h0;
        resolution <= RES_10;
        timerMode <= 1'b1;
        timerPeriod <= 12'h00F;
        pulse(0);
        d0 = evCnt[0];
        s0 = evCnt[3];
        pulse(1);
        waitFor(0, d0 + 3, 2000);
        pulse(3);
        waitFor(3, s0 + 1, 400);
        d0 = evCnt[0];
        repeat (1000) @(negedge mclk);
        check("sampling after stop", evCnt[0], d0);
        @(posedge mclk);
        timerMode <= 1'b0;
    endtask

    task automatic sStopCal();
        int s0;
        s0 = evCnt[3];
        pulse(3);
        pulse(3);
        repeat (5) @(negedge mclk);
        check("stopped while idle", evCnt[3], s0 + 2);
        // Calibration repeated as a drifting controller would
        repeat (2) begin
            s0 = evCnt[5];
            pulse(4);
            waitFor(5, s0 + 1, CAL_TB + 50);
            check("calibration finished", evCnt[5], s0 + 1);
        end
    endtask

    //------------------------------------------------------------------
    // Clock and main sequence
    //------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial begin
        srst = 1'b1;
        taskPulse = 5'h00;
        resolution = RES_12;
        oversamplingExponent = 3'h0;
        bufferCapacityCount = 16'h0010;
        timerMode = 1'b0;
        timerPeriod = 12'h000;
        foreach (chCfg[i]) chCfg[i] = '{SEL_NC, 4'h0, 1'b0, 1'b0, 3'h0};
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        check("amount after reset", resultAmount, 16'h0000);
        check("events after reset", evCnt.sum(), 0);
        sIdle();
        sOneShot();
        sScan();
        sBurst();
        sTimer();
        sStopCal();
        endOfTest();
    end
endmodule
